// *** xrp_exchange_protect.sv ***
// Relocation, range check and exchange package swap engine.
`timescale 1ns/10ps
module xrp_exchange_protect
  import xrp_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port.
  input wire logic [REG_AW-1:0] reg_addr,
  input wire logic [REG_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [REG_DW-1:0] reg_rdata,
  // Memory reference check.
  input wire xrp_ref_type ref_in,
  output logic ref_done,
  output logic ref_fault,
  output logic [ADDR_W-1:0] ref_abs,
  // Exit and interrupt events from the processor.
  input wire xrp_event_type ev,
  // Live context in, new context out.
  input wire xrp_ctx_type ctx_in,
  output xrp_ctx_type new_ctx,
  output logic ctx_load,
  output logic exec_hold,
  // Main memory port.
  output xrp_mem_type mem,
  input wire logic mem_ack,
  input wire logic [WORD_W-1:0] mem_rdata,
  // Interrupt.
  output logic irq
);

  xrp_regs_type r;
  xrp_regs_type next_r;
  logic [P_W:0] sum;
  logic below;
  logic above;
  logic range_bad;
  logic [FLAG_W-1:0] causes;
  logic [FLAG_W-1:0] start_flags;
  logic start;
  logic sw_run;
  logic sw_xchg;
  logic sup_wr;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  function automatic logic [ADDR_W-1:0] pkg_addr(input logic [PTR_W-1:0] p,
                                                 input logic [LOW_W-1:0] i);
    return {{(ADDR_W-XADDR_W){1'b0}}, p, i}; // RL5
  endfunction

  // Saved package: the flags written are the causes of this very exchange.
  function automatic xrp_words_type pack_words(input xrp_ctx_type c, input xrp_regs_type q,
                                               input logic [FLAG_W-1:0] f);
    xrp_words_type w;
    w = '0;
    for (int i = 0; i < NREG; i++) begin
      w[i][A_LSB +: A_W] = c.a[i]; // RL17
      w[W_S + i] = c.s[i]; // RL17
    end
    w[W_P][P_LSB +: P_W] = c.p; // RL15
    w[W_BASE][BASE_LSB +: BASE_W] = q.base;
    w[W_BOUND][BASE_LSB +: BASE_W] = q.bound;
    w[W_BOUND][MODE_LSB +: MODE_W] = q.modes; // RL11
    w[W_XCHG][PTR_LSB +: PTR_W] = q.ptr;
    w[W_XCHG][VL_LSB +: VL_W] = c.vl; // RL16
    w[W_XCHG][FLAG_LSB +: FLAG_W] = f; // RL9
    return w;
  endfunction

  // Relocated address; a negative relative address lands below the base.
  assign sum = {{(P_W-ADDR_W+1){1'b0}}, r.base, {LOW_W{1'b0}}}
             + {ref_in.rel[P_W-1], ref_in.rel}; // RL1 RL2
  assign below = ref_in.rel[P_W-1]; // RL4
  assign above = !below && (sum[P_W-1:0] >=
                 {{(P_W-ADDR_W){1'b0}}, r.bound, {LOW_W{1'b0}}}); // RL3 RL4
  assign range_bad = below || above;
  assign sw_run = reg_wr && (reg_addr == REG_CTRL) && reg_wdata[CTL_RUN];
  assign sw_xchg = reg_wr && (reg_addr == REG_CTRL) && reg_wdata[CTL_XCHG];
  assign sup_wr = reg_wr && ((reg_addr == REG_BASE) || (reg_addr == REG_BOUND) ||
                  (reg_addr == REG_PTR) || (reg_addr == REG_MODES));

  // Causes accepted while running; interrupts obey the mode bits.
  always_comb begin
    causes = '0;
    causes[FLG_PRANGE] = ref_in.valid && ref_in.fetch && range_bad; // RL4
    causes[FLG_ORANGE] = ref_in.valid && !ref_in.fetch && range_bad; // RL4
    causes[FLG_NORMAL] = ev.normal_exit; // RL8
    causes[FLG_ERROR] = ev.error_exit; // RL8
    if (!r.modes[MODE_MONITOR]) begin // RL12
      causes[FLG_IO] = ev.io;
      causes[FLG_RTC] = ev.rtc;
      causes[FLG_CONSOLE] = ev.console;
      causes[FLG_PARITY] = ev.parity && r.modes[MODE_PARITY]; // RL13
      causes[FLG_FP] = ev.fp_overflow && ev.fp_scalar && r.modes[MODE_FP]; // RL10 RL14
    end
  end

  always_comb begin
    next_r = r;
    next_r.ref_done = 1'b0;
    next_r.ref_fault = 1'b0;
    next_r.ctx_load = 1'b0;
    next_r.reg_rdata = '0;
    start = 1'b0;
    start_flags = '0;
    irq_set = '0;
    irq_clr = '0;
    if (reg_rd) begin
      case (reg_addr)
        REG_BASE: next_r.reg_rdata = REG_DW'(r.base);
        REG_BOUND: next_r.reg_rdata = REG_DW'(r.bound);
        REG_PTR: next_r.reg_rdata = REG_DW'(r.ptr);
        REG_FLAGS: next_r.reg_rdata = REG_DW'(r.flags);
        REG_MODES: next_r.reg_rdata = REG_DW'(r.modes);
        REG_CTRL: next_r.reg_rdata = REG_DW'({r.exec_hold && r.state != ST_STOP,
                                              r.state == ST_RUN});
        REG_IRQ_STAT: next_r.reg_rdata = REG_DW'(r.irq_status);
        REG_IRQ_MASK: next_r.reg_rdata = REG_DW'(r.irq_mask);
        default: next_r.reg_rdata = '0;
      endcase
    end
    if (reg_wr && reg_addr == REG_IRQ_STAT) begin
      irq_clr = reg_wdata[IRQ_W-1:0];
    end
    if (reg_wr && reg_addr == REG_IRQ_MASK) begin
      next_r.irq_mask = reg_wdata[IRQ_W-1:0];
    end
    // Supporting registers only take software writes while stopped.
    if (sup_wr && r.state != ST_STOP) begin
      irq_set[IRQ_REFUSED] = 1'b1; // RL7
    end else if (sup_wr) begin
      case (reg_addr)
        REG_BASE: next_r.base = reg_wdata[BASE_W-1:0];
        REG_BOUND: next_r.bound = reg_wdata[BASE_W-1:0];
        REG_PTR: next_r.ptr = reg_wdata[PTR_W-1:0];
        default: next_r.modes = reg_wdata[MODE_W-1:0];
      endcase
    end
    case (r.state)
      ST_STOP: begin
        if (sw_xchg) begin
          start = 1'b1;
        end else if (sw_run) begin
          next_r.state = ST_RUN;
          next_r.exec_hold = 1'b0;
        end
      end
      ST_RUN: begin
        if (ref_in.valid) begin
          next_r.ref_done = 1'b1;
          next_r.ref_fault = range_bad; // RL4
          next_r.ref_abs = sum[ADDR_W-1:0]; // RL1
          irq_set[IRQ_RANGE] = range_bad;
        end
        if (|causes || sw_xchg) begin
          start = 1'b1; // RL6
          start_flags = causes; // RL8
        end
      end
      ST_READ: begin
        if (mem_ack) begin
          next_r.in_words[r.idx] = mem_rdata;
          next_r.mem.we = 1'b1;
          next_r.mem.wdata = r.out_words[r.idx]; // RL6
          next_r.state = ST_WRITE;
        end
      end
      ST_WRITE: begin
        if (mem_ack && r.idx == LOW_W'(PKG_WORDS-1)) begin
          next_r.mem.req = 1'b0;
          next_r.mem.we = 1'b0;
          next_r.state = ST_DONE; // RL18
        end else if (mem_ack) begin
          next_r.idx = r.idx + 1'b1;
          next_r.mem.we = 1'b0;
          next_r.mem.addr = pkg_addr(r.ptr, r.idx + 1'b1);
          next_r.state = ST_READ;
        end
      end
      ST_DONE: begin
        // New context comes only from the package just read.
        for (int i = 0; i < NREG; i++) begin
          next_r.new_ctx.a[i] = r.in_words[i][A_LSB +: A_W]; // RL17
          next_r.new_ctx.s[i] = r.in_words[W_S + i]; // RL17
        end
        next_r.new_ctx.p = r.in_words[W_P][P_LSB +: P_W]; // RL15
        next_r.new_ctx.vl = r.in_words[W_XCHG][VL_LSB +: VL_W]; // RL16
        next_r.base = r.in_words[W_BASE][BASE_LSB +: BASE_W]; // RL7
        next_r.bound = r.in_words[W_BOUND][BASE_LSB +: BASE_W];
        next_r.modes = r.in_words[W_BOUND][MODE_LSB +: MODE_W]; // RL11
        next_r.ptr = r.in_words[W_XCHG][PTR_LSB +: PTR_W];
        next_r.flags = r.in_words[W_XCHG][FLAG_LSB +: FLAG_W]; // RL9
        next_r.ctx_load = 1'b1;
        next_r.exec_hold = 1'b0; // RL18
        next_r.state = ST_RUN;
        irq_set[IRQ_DONE] = 1'b1;
      end
      default: begin
        next_r.state = ST_STOP;
        next_r.exec_hold = 1'b1;
        next_r.mem = '0;
      end
    endcase
    if (start) begin
      next_r.state = ST_READ;
      next_r.exec_hold = 1'b1;
      next_r.idx = '0;
      next_r.flags = start_flags; // RL8
      next_r.out_words = pack_words(ctx_in, r, start_flags); // RL6
      next_r.mem.req = 1'b1;
      next_r.mem.we = 1'b0;
      next_r.mem.addr = pkg_addr(r.ptr, '0); // RL5
    end
    // A new event beats a clear in the same cycle.
    next_r.irq_status = (r.irq_status & ~irq_clr) | irq_set;
    next_r.irq = |(next_r.irq_status & next_r.irq_mask);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.state <= ST_STOP;
      r.exec_hold <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign reg_rdata = r.reg_rdata;
  assign ref_done = r.ref_done;
  assign ref_fault = r.ref_fault;
  assign ref_abs = r.ref_abs;
  assign new_ctx = r.new_ctx;
  assign ctx_load = r.ctx_load;
  assign exec_hold = r.exec_hold;
  assign mem = r.mem;
  assign irq = r.irq;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_abs_addr_formed: assert property ( // RL1
    ref_done |-> ref_abs == ADDR_W'({r.base, {LOW_W{1'b0}}} + $past(ref_in.rel[ADDR_W-1:0])))
    else $error("absolute address not base times sixteen plus relative");
  a_accepted_in_window: assert property ( // RL3
    ref_done && !ref_fault |-> ref_abs >= {r.base, {LOW_W{1'b0}}}
                               && ref_abs < {r.bound, {LOW_W{1'b0}}})
    else $error("reference outside base and bound was accepted");
  a_fault_ends_run: assert property ( // RL4
    ref_fault |-> exec_hold && mem.req && (r.flags[FLG_PRANGE] || r.flags[FLG_ORANGE]))
    else $error("range fault did not end the interval");
  a_support_stable: assert property ( // RL7
    r.state == ST_RUN && $past(r.state == ST_RUN)
      |-> $stable(r.base) && $stable(r.bound) && $stable(r.ptr) && $stable(r.modes))
    else $error("supporting register changed while running");
  a_package_address: assert property ( // RL5
    mem.req |-> mem.addr[ADDR_W-1:LOW_W] == {{(ADDR_W-XADDR_W){1'b0}}, r.ptr})
    else $error("package access outside the swap pointer block");
  a_monitor_mutes: assert property ( // RL12
    $rose(exec_hold) && r.modes[MODE_MONITOR] |-> (r.flags & FLG_INTR) == '0)
    else $error("interrupt taken in monitor mode");
  a_parity_gated: assert property ( // RL13
    $rose(exec_hold) && !r.modes[MODE_PARITY] |-> !r.flags[FLG_PARITY])
    else $error("parity interrupt without parity mode");
  a_fp_gated: assert property ( // RL14
    $rose(exec_hold) && !r.modes[MODE_FP] |-> !r.flags[FLG_FP])
    else $error("floating-point interrupt without its mode");
  a_fp_scalar_only: assert property ( // RL10
    $rose(exec_hold) && r.flags[FLG_FP] |-> $past(ev.fp_scalar))
    else $error("floating-point flag set for a vector operation");
  a_swap_complete: assert property ( // RL18
    ctx_load |-> $past(r.idx, 2) == LOW_W'(PKG_WORDS-1) && $past(mem.we && mem_ack, 2)
                 && !mem.req && !exec_hold)
    else $error("context loaded before all sixteen words swapped");

endmodule // xrp_exchange_protect

// *** xrp_mem_model.sv ***
// Main memory model that holds exchange packages for the swap engine.
`timescale 1ns/10ps
module xrp_mem_model
  import xrp_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Memory port.
  input wire xrp_mem_type mem,
  output logic mem_ack,
  output logic [WORD_W-1:0] mem_rdata,
  // Answer delay in cycles, zero answers in the cycle of the request.
  input wire logic [3:0] lat
);
  logic [WORD_W-1:0] words [0:4095];
  logic [3:0] wait_cnt;
  logic [WORD_W-1:0] last_data;
  assign mem_ack = mem.req && (wait_cnt == lat);
  // Outside an answered read the lines flip each cycle, so stale data never looks valid.
  assign mem_rdata = (mem_ack && !mem.we) ? words[mem.addr[11:0]] : ~last_data;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt <= 4'h0;
      last_data <= 64'h0;
    end else begin
      last_data <= mem_rdata;
      if (mem_ack) begin
        wait_cnt <= 4'h0;
      end else if (mem.req) begin
        wait_cnt <= wait_cnt + 4'h1;
      end
      if (mem_ack && mem.we) begin
        words[mem.addr[11:0]] <= mem.wdata;
      end
    end
  end
endmodule // xrp_mem_model

// *** xrp_pkg.sv ***
// Constants and types of the exchange and range protect block.
// How it works
// RL1: Absolute address is base times sixteen plus relative.
// RL2: Base holds upper 18 of 22 address bits.
// RL3: Bound holds upper 18 of 22 address bits.
// RL4: Out-of-range reference sets range flag, ends interval.
// RL5: Swap pointer is upper 8 of 12 bits.
// RL6: Interval end swaps state with memory package.
// RL7: Supporting registers change only during an exchange or by software writes while stopped.
// RL8: Nine cause flags record why exchange happened.
// RL9: Cause flags sit at package bits 31 to 39.
// RL10: Floating-point flag set for scalar references only.
// RL11: Three mode bits sit at package bits 31-33.
// RL12: Monitor mode inhibits every interrupt.
// RL13: Parity interrupt needs the parity mode bit.
// RL14: Floating-point interrupt needs its mode bit.
// RL15: Program address is word address plus parcel.
// RL16: Element count is saved and restored too.
// RL17: Sixteen-word package layout with index, scalar registers.
// RL18: Exchange finishes all package traffic before resuming.
package xrp_pkg;
  localparam int ADDR_W = 22;
  localparam int BASE_W = 18;
  localparam int LOW_W = 4;
  localparam int PTR_W = 8;
  localparam int XADDR_W = 12;
  localparam int FLAG_W = 9;
  localparam int MODE_W = 3;
  localparam int P_W = 24;
  localparam int VL_W = 7;
  localparam int A_W = 24;
  localparam int S_W = 64;
  localparam int NREG = 8;
  localparam int WORD_W = 64;
  localparam int PKG_WORDS = 16;
  localparam int REG_AW = 4;
  localparam int REG_DW = 32;
  // Register indices on the register port.
  localparam logic [REG_AW-1:0] REG_BASE = 4'h0;
  localparam logic [REG_AW-1:0] REG_BOUND = 4'h1;
  localparam logic [REG_AW-1:0] REG_PTR = 4'h2;
  localparam logic [REG_AW-1:0] REG_FLAGS = 4'h3;
  localparam logic [REG_AW-1:0] REG_MODES = 4'h4;
  localparam logic [REG_AW-1:0] REG_CTRL = 4'h5;
  localparam logic [REG_AW-1:0] REG_IRQ_STAT = 4'h6;
  localparam logic [REG_AW-1:0] REG_IRQ_MASK = 4'h7;
  localparam int CTL_RUN = 0;
  localparam int CTL_XCHG = 1;
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_RANGE = 1;
  localparam int IRQ_REFUSED = 2;
  // Cause flags; bit 8 lands in package bit 31 counted from the left.
  localparam int FLG_NORMAL = 0;
  localparam int FLG_ERROR = 1;
  localparam int FLG_IO = 2;
  localparam int FLG_PARITY = 3;
  localparam int FLG_PRANGE = 4;
  localparam int FLG_ORANGE = 5;
  localparam int FLG_FP = 6;
  localparam int FLG_RTC = 7;
  localparam int FLG_CONSOLE = 8;
  localparam logic [FLAG_W-1:0] FLG_INTR = 9'h1CC;
  localparam int MODE_MONITOR = 0;
  localparam int MODE_PARITY = 1;
  localparam int MODE_FP = 2;
  // Package word indices and field positions, counted from the right.
  localparam int W_P = 0;
  localparam int W_BASE = 1;
  localparam int W_BOUND = 2;
  localparam int W_XCHG = 3;
  localparam int W_S = 8;
  localparam int A_LSB = 0;
  localparam int P_LSB = 24;
  localparam int BASE_LSB = 36;
  localparam int MODE_LSB = 30;
  localparam int PTR_LSB = 40;
  localparam int VL_LSB = 33;
  localparam int FLAG_LSB = 24;
  typedef logic [PKG_WORDS-1:0][WORD_W-1:0] xrp_words_type;
  typedef struct packed {
    logic [NREG-1:0][A_W-1:0] a;
    logic [NREG-1:0][S_W-1:0] s;
    logic [P_W-1:0] p;
    logic [VL_W-1:0] vl;
  } xrp_ctx_type;
  typedef struct packed {
    logic console;
    logic rtc;
    logic fp_overflow;
    logic fp_scalar;
    logic io;
    logic parity;
    logic error_exit;
    logic normal_exit;
  } xrp_event_type;
  typedef struct packed {
    logic valid;
    logic fetch;
    logic [P_W-1:0] rel;
  } xrp_ref_type;
  typedef struct packed {
    logic req;
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } xrp_mem_type;
  typedef enum logic [4:0] {
    ST_STOP = 5'h01,
    ST_RUN = 5'h02,
    ST_READ = 5'h04,
    ST_WRITE = 5'h08,
    ST_DONE = 5'h10
  } xrp_state_type;
  typedef struct packed {
    xrp_state_type state;
    logic [BASE_W-1:0] base;
    logic [BASE_W-1:0] bound;
    logic [PTR_W-1:0] ptr;
    logic [MODE_W-1:0] modes;
    logic [FLAG_W-1:0] flags;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [LOW_W-1:0] idx;
    xrp_words_type out_words;
    xrp_words_type in_words;
    xrp_mem_type mem;
    logic [REG_DW-1:0] reg_rdata;
    logic ref_done;
    logic ref_fault;
    logic [ADDR_W-1:0] ref_abs;
    xrp_ctx_type new_ctx;
    logic ctx_load;
    logic exec_hold;
    logic irq;
  } xrp_regs_type;
endpackage

// *** xrp_tb.sv ***
// Self-checking testbench of the exchange and range protect block.
`timescale 1ns/10ps
module testbench
  import xrp_pkg::*;
;
  int errors = 0;
  int cmp_count = 0;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [REG_AW-1:0] reg_addr = '0;
  logic [REG_DW-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [REG_DW-1:0] reg_rdata;
  xrp_ref_type ref_in = '0;
  logic ref_done, ref_fault, ctx_load, exec_hold, mem_ack, irq;
  logic [ADDR_W-1:0] ref_abs;
  xrp_event_type ev = '0;
  xrp_ctx_type ctx_in, new_ctx, ctx_b;
  xrp_mem_type mem;
  logic [WORD_W-1:0] mem_rdata;
  logic [3:0] lat = 4'h2;
  logic [2:0] md [13] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h2, 3'h0, 3'h4, 3'h4, 3'h1, 3'h7,
    3'h1};
  logic [7:0] evt [13] = '{8'h01, 8'h02, 8'h08, 8'h40, 8'h80, 8'h04, 8'h04, 8'h30, 8'h30, 8'h20,
    8'h88, 8'h34, 8'h03};
  logic [8:0] fl [13] = '{9'h001, 9'h002, 9'h004, 9'h080, 9'h100, 9'h000, 9'h008, 9'h000, 9'h040,
    9'h000, 9'h000, 9'h000, 9'h003};

  xrp_exchange_protect dut (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .ref_in, .ref_done, .ref_fault, .ref_abs, .ev, .ctx_in, .new_ctx, .ctx_load,
    .exec_hold, .mem, .mem_ack, .mem_rdata, .irq);
  xrp_mem_model u_mem (.core_clk, .rst_n, .mem, .mem_ack, .mem_rdata, .lat);

  always #4 core_clk = ~core_clk;

  function automatic xrp_words_type build(input xrp_ctx_type c, input logic [17:0] b,
    input logic [17:0] l, input logic [7:0] x, input logic [2:0] m, input logic [8:0] f);
    xrp_words_type w;
    w = '0;
    for (int i = 0; i < NREG; i++) begin
      w[i][A_W-1:0] = c.a[i];
      w[W_S+i] = c.s[i];
    end
    w[W_P][P_LSB+:P_W] = c.p;
    w[W_BASE][BASE_LSB+:BASE_W] = b;
    w[W_BOUND][BASE_LSB+:BASE_W] = l;
    w[W_BOUND][63-33+:MODE_W] = m;
    w[W_XCHG][PTR_LSB+:PTR_W] = x;
    w[W_XCHG][VL_LSB+:VL_W] = c.vl;
    w[W_XCHG][63-39+:FLAG_W] = f;
    return w;
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask

  task automatic ref_chk(input logic f, input logic [23:0] rel, input logic flt,
    input logic [21:0] abs);
    @(posedge core_clk);
    ref_in <= '{valid: 1'b1, fetch: f, rel: rel};
    @(posedge core_clk);
    ref_in.valid <= 1'b0;
    #1 chk(ref_done, 1);
    chk(ref_fault, flt);
    if (!flt) begin
      chk(ref_abs, abs);
    end
  endtask

  // The swap pointer stays 3 throughout, so every package lives at word 48.
  task automatic preload(input xrp_words_type w);
    for (int i = 0; i < PKG_WORDS; i++) begin
      u_mem.words[48+i] = w[i];
    end
  endtask

  task automatic check_mem(input xrp_words_type w);
    for (int i = 0; i < PKG_WORDS; i++) begin
      chk(u_mem.words[48+i], w[i]);
    end
  endtask

  task automatic wait_load;
    for (int n = 0; n < 500; n++) begin
      @(posedge core_clk);
      #1;
      if (ctx_load === 1'b1) return;
    end
    errors++;
    $display("[ERR] %0t no context load", $time);
  endtask

  task automatic finish_test;
    if (errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #200000;
    errors++;
    $display("[ERR] %0t timeout", $time);
    finish_test;
  end

  initial begin
    for (int i = 0; i < NREG; i++) begin
      ctx_in.a[i] = 24'hA00000 + 24'(i);
      ctx_in.s[i] = 64'h5000000000000000 + 64'(i);
      ctx_b.a[i] = 24'h0B0000 + 24'(i);
      ctx_b.s[i] = 64'hC000000000000000 + 64'(i);
    end
    ctx_in.p = 24'h000123;
    ctx_in.vl = 7'h40;
    ctx_b.p = 24'h000206;
    ctx_b.vl = 7'h11;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    #1 chk(exec_hold, 1);
    wr(REG_BASE, 1);
    wr(REG_BOUND, 2);
    wr(REG_PTR, 3);
    wr(REG_MODES, 4);
    wr(REG_FLAGS, 32'h1FF);
    rd(REG_BASE, 1);
    rd(REG_BOUND, 2);
    rd(REG_PTR, 3);
    rd(REG_MODES, 4);
    rd(REG_FLAGS, 0);
    rd(4'h9, 0);
    preload(build(ctx_b, 18'h2, 18'h6, 8'h3, 3'h1, 9'h155));
    wr(REG_CTRL, 1);
    rd(REG_CTRL, 1);
    ref_chk(1'b1, 24'h5, 1'b0, 22'h15);
    ref_chk(1'b0, 24'hF, 1'b0, 22'h1F);
    wr(REG_BASE, 7);
    rd(REG_BASE, 1);
    ref_chk(1'b0, 24'h10, 1'b1, 22'h0);
    chk(mem.req, 1);
    chk(exec_hold, 1);
    wait_load;
    chk(new_ctx === ctx_b, 1);
    check_mem(build(ctx_in, 18'h1, 18'h2, 8'h3, 3'h4, 9'h020));
    rd(REG_BASE, 2);
    rd(REG_BOUND, 6);
    rd(REG_FLAGS, 32'h155);
    rd(REG_MODES, 1);
    rd(REG_IRQ_STAT, 7);
    chk(irq, 0);
    wr(REG_IRQ_MASK, 2);
    rd(REG_IRQ_MASK, 2);
    chk(irq, 1);
    wr(REG_IRQ_STAT, 7);
    rd(REG_IRQ_STAT, 0);
    chk(irq, 0);
    lat <= 4'h0;
    ref_chk(1'b1, 24'hFFFFFF, 1'b1, 22'h0);
    wait_load;
    check_mem(build(ctx_in, 18'h2, 18'h6, 8'h3, 3'h1, 9'h010));
    for (int k = 0; k < 13; k++) begin
      lat <= k[0] ? 4'h3 : 4'h0;
      preload(build(ctx_b, 18'h2, 18'h6, 8'h3, md[k], 9'h0));
      wr(REG_CTRL, 2);
      wait_load;
      @(posedge core_clk);
      ev <= evt[k];
      @(posedge core_clk);
      ev <= '0;
      repeat (2) @(posedge core_clk);
      #1 chk(exec_hold, 64'(fl[k] != 9'h0));
      if (exec_hold !== 1'b1) begin
        wr(REG_CTRL, 2);
      end
      wait_load;
      chk(u_mem.words[51][63-39+:FLAG_W], 64'(fl[k]));
    end
    finish_test;
  end
endmodule // testbench
